/* bench/ocs_cfg_model.sv */
// Purpose: configuration engine stand-in driving the selection port
// Assumes: one selection pulse per send call, launched just after a clk edge
// Notes:   released code lines show the inverse of the last value
`timescale 1ns/1ns
`include "ocs_defs.svh"

module ocs_cfg_model (
    input  wire logic                   clk,
    output logic                        cfg_sel_valid,
    output logic                        cfg_sel_present,
    output logic [`OCS_CODE_W-1:0]      cfg_sel_code
);
    // idle outputs at time zero
    initial begin
        cfg_sel_valid   = 1'b0;
        cfg_sel_present = 1'b0;
        cfg_sel_code    = 5'h00;
    end

    // one pulse after lag+1 clock edges, prompt or slow
    task automatic send(input logic pres, input logic [`OCS_CODE_W-1:0] code, input int lag);
        repeat (lag + 1) @(posedge clk);
        cfg_sel_valid   <= 1'b1;
        cfg_sel_present <= pres;
        cfg_sel_code    <= code;
        @(posedge clk);
        cfg_sel_valid   <= 1'b0;
        cfg_sel_present <= ~pres;  // released lines do not hold
        cfg_sel_code    <= ~code;
    endtask
endmodule

/* bench/tb.sv */
// Purpose: self-checking bench for the oscillator and master clock selector
// Assumes: 100 ns clock, outputs sampled on the falling edge
// Notes:   periods come from a tracker sampling mclk_ce at the rising edge
`timescale 1ns/1ns
`include "ocs_defs.svh"

module tb;
    logic                   clk, sys_rst, cfg_osc_en, user_osc_en, route_to_pll;
    logic                   cfg_sel_valid, cfg_sel_present;
    logic [`OCS_CODE_W-1:0] cfg_sel_code, mclk_code;
    logic                   osc_tree_ce, osc_pll_ref_ce, mclk_ce, mclk_switched;
    int                     bad_count, checks_done, cyc, last, gap;
    // cycles per master clock pulse by code, 266 MHz base over ratio
    logic [7:0]             ratio [0:20] = '{8'h80, 8'h6c, 8'h54, 8'h3e, 8'h30, 8'h26, 8'h20, 8'h1d,
                                             8'h1a, 8'h14, 8'h12, 8'h0d, 8'h0a, 8'h09, 8'h08, 8'h07,
                                             8'h06, 8'h05, 8'h04, 8'h03, 8'h02};

    // clock and time-zero values
    initial begin
        clk = 1'b0; sys_rst = 1'b1; cfg_osc_en = 1'b0; user_osc_en = 1'b0; route_to_pll = 1'b0;
        bad_count = 0; checks_done = 0; cyc = 0; last = 0; gap = 0;
    end
    always #50 clk = ~clk;

    ocs_top i_ocs_top (.clk(clk), .sys_rst(sys_rst), .cfg_osc_en(cfg_osc_en), .user_osc_en(user_osc_en),
        .route_to_pll(route_to_pll), .cfg_sel_valid(cfg_sel_valid), .cfg_sel_present(cfg_sel_present),
        .cfg_sel_code(cfg_sel_code), .osc_tree_ce(osc_tree_ce), .osc_pll_ref_ce(osc_pll_ref_ce),
        .mclk_ce(mclk_ce), .mclk_code(mclk_code), .mclk_switched(mclk_switched));
    ocs_cfg_model i_ocs_cfg_model (.clk(clk), .cfg_sel_valid(cfg_sel_valid),
        .cfg_sel_present(cfg_sel_present), .cfg_sel_code(cfg_sel_code));

    // gap between master clock pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mclk_ce === 1'b1) begin
            gap  <= cyc - last;
            last <= cyc;
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // wait for the next pulse, then one more edge so the tracker has it
    task automatic next_ce();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (mclk_ce !== 1'b1 && n < 400);
        if (n >= 400) begin
            bad_count++;
            $display("wrong value mclk_ce expected pulse seen none");
            complete_run();
        end
        @(negedge clk);
    endtask

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk_val("code after reset", 8'h00, {3'b000, mclk_code});
        chk_bit("switched after reset", 1'b0, mclk_switched);
    endtask

    // default rate, missing choice and out-of-range code
    task automatic default_rate();
        next_ce();
        next_ce();
        chk_val("default period", ratio[0], gap[7:0]);
        i_ocs_cfg_model.send(1'b0, 5'h05, 0);
        i_ocs_cfg_model.send(1'b1, 5'h15, 3);
        next_ce();
        next_ce();
        chk_val("no choice period", ratio[0], gap[7:0]);
        chk_val("no choice code", 8'h00, {3'b000, mclk_code});
        chk_bit("no choice switched", 1'b0, mclk_switched);
    endtask

    // second choice before the switch wins; switch lands on a period edge
    task automatic replace_pending();
        next_ce();
        i_ocs_cfg_model.send(1'b1, 5'h03, 0);
        i_ocs_cfg_model.send(1'b1, 5'h0c, 0);
        next_ce();
        chk_val("switch period", ratio[0], gap[7:0]);
        chk_val("replaced code", 8'h0c, {3'b000, mclk_code});
        chk_bit("switched", 1'b1, mclk_switched);
    endtask

    // every code in turn, old period kept whole then new period
    task automatic select_all();
        logic [4:0] c, old;
        int         lag;
        old = 5'h0c;
        for (int k = 1; k <= 21; k++) begin
            c   = (k == 21) ? 5'h00 : k[4:0];
            lag = k % 3;
            i_ocs_cfg_model.send(1'b1, c, lag);
            // taken lag+3 edges after the last pulse; a boundary on that very edge still closes an old period
            if ((lag + 3) % ratio[old] == 0) begin
                next_ce();
                chk_val("held code", {3'b000, old}, {3'b000, mclk_code});
            end
            next_ce();
            chk_val("old period", ratio[old], gap[7:0]);
            chk_val("new code", {3'b000, c}, {3'b000, mclk_code});
            next_ce();
            chk_val("new period", ratio[c], gap[7:0]);
            old = c;
        end
    endtask

    // enable pair and route, pulses counted over 20 cycles
    task automatic osc_case(input logic ce, input logic ue, input logic rt, input logic [7:0] nt,
                            input logic [7:0] np);
        logic [7:0] t, p;
        @(posedge clk);
        cfg_osc_en <= ce; user_osc_en <= ue; route_to_pll <= rt;
        repeat (8) @(posedge clk);
        t = 8'h00;
        p = 8'h00;
        repeat (20) begin
            @(negedge clk);
            t = t + {7'h00, osc_tree_ce === 1'b1};
            p = p + {7'h00, osc_pll_ref_ce === 1'b1};
        end
        chk_val("tree pulses", nt, t);
        chk_val("pll pulses", np, p);
    endtask

    // main sequence
    initial begin
        do_reset();
        default_rate();
        replace_pending();
        select_all();
        osc_case(1'b1, 1'b1, 1'b0, 8'h0a, 8'h00);
        osc_case(1'b1, 1'b1, 1'b1, 8'h00, 8'h0a);
        osc_case(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
        osc_case(1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
        do_reset();
        complete_run();
    end
endmodule

/* hdl/ocs_defs.svh */
// Purpose: constants for the oscillator and master clock selector
// Assumes: clk stands in for the base oscillation at twice the undivided rate
// Notes:   divide ratios are in half-periods of the undivided oscillator
`ifndef OCS_DEFS_SVH
`define OCS_DEFS_SVH

// ----------------------------------------------------------------------------
// selection codes
// ----------------------------------------------------------------------------
`define OCS_CODE_W        5
`define OCS_RATIO_W       8
`define OCS_CODE_DEFAULT  5'h00
`define OCS_CODE_MAX      5'h14

// ----------------------------------------------------------------------------
// divide ratios, code 0 in the low byte, code 20 in the high byte
// ----------------------------------------------------------------------------
`define OCS_RATIO_TABLE {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, \
                         8'h09, 8'h0a, 8'h0d, 8'h12, 8'h14, 8'h1a, 8'h1d, \
                         8'h20, 8'h26, 8'h30, 8'h3e, 8'h54, 8'h6c, 8'h80}
`define OCS_OSC_RATIO     8'h02

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define OCS_CLK_PERIOD_NS 100
`define OCS_T_STABLE_NS   100
`define OCS_STABLE_CYC    (((`OCS_T_STABLE_NS + `OCS_CLK_PERIOD_NS - 1) / `OCS_CLK_PERIOD_NS) < 1 ? 1 : \
                           ((`OCS_T_STABLE_NS + `OCS_CLK_PERIOD_NS - 1) / `OCS_CLK_PERIOD_NS))
`define OCS_STAB_W        4

`endif

/* hdl/ocs_div.sv */
// Purpose: counter divider producing a one-cycle enable per period
// Assumes: ratio is at least 2 and changes only on the wrap cycle
// Notes:   wrap is combinational so the owner can swap ratio at a period edge
`timescale 1ns/1ns
`include "ocs_defs.svh"

module ocs_div (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    run,
    input  wire logic [`OCS_RATIO_W-1:0] ratio,
    output logic                         tick,
    output logic                         wrap
);
    import ocs_pkg::*;

    ocs_div_st_t s_q;
    ocs_div_st_t s_d;

    // ------------------------------------------------------------------------
    // counting
    // ------------------------------------------------------------------------
    // last count of the current period
    assign wrap = run && (s_q.cnt == ratio - 8'h01);
    assign tick = s_q.tick;

    // divide the base oscillation, never retune it
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 8'h00;
        end else if (wrap) begin
            s_d.cnt  = 8'h00; // RULE_03
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01; // RULE_03
        end
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_tick_single: assert property (s_q.tick |=> !s_q.tick) // RULE_03
        else $error("divider tick longer than one cycle");
    a_count_bound: assert property (run |-> s_q.cnt < ratio) // RULE_03
        else $error("divider count beyond ratio");

endmodule

/* hdl/ocs_pkg.sv */
// Purpose: types for the oscillator and master clock selector
// Assumes: constants come from ocs_defs.svh
// Notes:   state encodings are one-hot
`include "ocs_defs.svh"

package ocs_pkg;

    // master clock selection state
    typedef enum logic [2:0] {
        OCS_MCLK_DEFAULT  = 3'b001,
        OCS_MCLK_PENDING  = 3'b010,
        OCS_MCLK_SELECTED = 3'b100
    } ocs_mclk_st_t;

    // divider state
    typedef struct packed {
        logic [`OCS_RATIO_W-1:0] cnt;
        logic                    tick;
    } ocs_div_st_t;

    // top state
    typedef struct packed {
        ocs_mclk_st_t            st;
        logic [`OCS_CODE_W-1:0]  code;
        logic [`OCS_CODE_W-1:0]  pend;
        logic [`OCS_STAB_W-1:0]  stab;
        logic                    tree_ce;
        logic                    pll_ce;
        logic                    switched;
    } ocs_top_st_t;

endpackage

/* hdl/ocs_top.sv */
// Purpose: on-chip oscillator gating, routing and master clock selection
// Assumes: config inputs are static or pulsed in step with clk
// Notes:   osc_tree_ce, osc_pll_ref_ce and mclk_ce are clock enables; clk is the base oscillation
`timescale 1ns/1ns
`include "ocs_defs.svh"

// Contract
// RULE_01: oscillator runs only when config bit and fabric input both enable it.
// RULE_02: oscillator output goes either to the clock tree or the pll reference.
// RULE_03: output frequencies come from dividing a base oscillation in logic.
// RULE_04: after power-up the master clock runs at the 2.08 MHz default.
// RULE_05: master clock changes only after selection bits are fully received.
// RULE_06: with no explicit choice the master clock stays at 2.08 MHz.
// RULE_07: selection takes one of 21 frequencies, 2.08 up to 133 MHz.
// RULE_08: the switch to the new master clock is free of glitches and runts.
module ocs_top (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   cfg_osc_en,
    input  wire logic                   user_osc_en,
    input  wire logic                   route_to_pll,
    input  wire logic                   cfg_sel_valid,
    input  wire logic                   cfg_sel_present,
    input  wire logic [`OCS_CODE_W-1:0] cfg_sel_code,
    output logic                        osc_tree_ce,
    output logic                        osc_pll_ref_ce,
    output logic                        mclk_ce,
    output logic [`OCS_CODE_W-1:0]      mclk_code,
    output logic                        mclk_switched
);
    import ocs_pkg::*;

    localparam logic [`OCS_STAB_W-1:0] STAB_CYC = `OCS_STAB_W'(`OCS_STABLE_CYC);
    localparam logic [20*8+7:0]        RATIOS   = `OCS_RATIO_TABLE;

    ocs_top_st_t             s_q;
    ocs_top_st_t             s_d;
    logic                    osc_run;
    logic                    osc_tick;
    logic                    mclk_wrap;
    logic [`OCS_RATIO_W-1:0] mclk_ratio;

    // ------------------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------------------
    // divide ratio of a selection code
    function automatic logic [`OCS_RATIO_W-1:0] ocs_ratio(input logic [`OCS_CODE_W-1:0] code);
        ocs_ratio = RATIOS[code*8 +: 8];
    endfunction

    // only the 21 listed frequencies are legal
    function automatic logic ocs_code_ok(input logic [`OCS_CODE_W-1:0] code);
        ocs_code_ok = (code <= `OCS_CODE_MAX);
    endfunction

    // both enables must agree
    assign osc_run    = cfg_osc_en && user_osc_en; // RULE_01
    assign mclk_ratio = ocs_ratio(s_q.code);

    // ------------------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------------------
    // undivided oscillator, held until the startup time has passed
    ocs_div u_osc_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (osc_run && (s_q.stab == STAB_CYC)),
        .ratio   (`OCS_OSC_RATIO),
        .tick    (osc_tick),
        .wrap    ()
    );

    // master configuration clock, free running from reset
    ocs_div u_mclk_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (1'b1),
        .ratio   (mclk_ratio), // RULE_03
        .tick    (mclk_ce),
        .wrap    (mclk_wrap)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // startup wait after enable
        if (!osc_run) begin
            s_d.stab = '0;
        end else if (s_q.stab != STAB_CYC) begin
            s_d.stab = s_q.stab + `OCS_STAB_W'(1);
        end
        // route the oscillator to one consumer only
        s_d.tree_ce = osc_run && osc_tick && !route_to_pll; // RULE_02
        s_d.pll_ce  = osc_run && osc_tick && route_to_pll;  // RULE_02
        // master clock selection
        case (s_q.st)
            OCS_MCLK_DEFAULT: begin
                s_d.code = `OCS_CODE_DEFAULT; // RULE_04
            end
            OCS_MCLK_PENDING: begin
                // swap only at a period boundary
                if (mclk_wrap) begin
                    s_d.code = s_q.pend; // RULE_08
                    s_d.st   = OCS_MCLK_SELECTED;
                end
            end
            OCS_MCLK_SELECTED: begin
                s_d.st = OCS_MCLK_SELECTED;
            end
            default: begin
                s_d.st   = OCS_MCLK_DEFAULT;
                s_d.code = `OCS_CODE_DEFAULT;
            end
        endcase
        // selection bits complete; absent or illegal choice changes nothing
        if (cfg_sel_valid && cfg_sel_present && ocs_code_ok(cfg_sel_code)) begin // RULE_06 RULE_07
            s_d.pend = cfg_sel_code; // RULE_05
            s_d.st   = OCS_MCLK_PENDING;
        end
        s_d.switched = (s_d.st == OCS_MCLK_SELECTED);
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q      <= '0;
            s_q.st   <= OCS_MCLK_DEFAULT;
            s_q.code <= `OCS_CODE_DEFAULT; // RULE_04
            s_q.pend <= `OCS_CODE_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    assign osc_tree_ce    = s_q.tree_ce;
    assign osc_pll_ref_ce = s_q.pll_ce;
    assign mclk_code      = s_q.code;
    assign mclk_switched  = s_q.switched;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_osc_off_quiet: assert property (!osc_run |=> !osc_tree_ce && !osc_pll_ref_ce) // RULE_01
        else $error("oscillator output while disabled");
    a_route_pll: assert property (osc_pll_ref_ce |-> $past(route_to_pll) && !osc_tree_ce) // RULE_02
        else $error("pll reference pulse without pll routing");
    a_route_tree: assert property (osc_tree_ce |-> !$past(route_to_pll)) // RULE_02
        else $error("tree pulse while routed to pll");
    a_default_code: assert property (s_q.st == OCS_MCLK_DEFAULT |-> mclk_code == `OCS_CODE_DEFAULT) // RULE_04
        else $error("master clock off default before selection");
    a_switch_after_sel: assert property ($changed(mclk_code) |-> $past(s_q.st) == OCS_MCLK_PENDING) // RULE_05
        else $error("master clock changed without pending selection");
    a_no_choice_keep: assert property (
        cfg_sel_valid && !cfg_sel_present && s_q.st == OCS_MCLK_DEFAULT |=> mclk_code == `OCS_CODE_DEFAULT) // RULE_06
        else $error("master clock left default without a choice");
    a_code_legal: assert property (mclk_code <= `OCS_CODE_MAX) // RULE_07
        else $error("illegal master clock code");
    // new code shows together with the pulse that closes the old period
    a_switch_at_edge: assert property ($changed(mclk_code) |-> $past(mclk_wrap) && mclk_ce) // RULE_08
        else $error("master clock switched mid period");

    c_switch_done: cover property (s_q.st == OCS_MCLK_PENDING ##1 s_q.st == OCS_MCLK_SELECTED);
    c_tree_pulse:  cover property (osc_tree_ce);
    c_pll_pulse:   cover property (osc_pll_ref_ce);

endmodule
